// ===== include/usrif_pkg.sv
// Constants for the serial port register interface: offsets, fields, reset values, codes.
// Assumes a single 32-bit AHB-Lite slave port with each register on an aligned word.
// Summary of operation
// - Data location writes go to transmit buffer; reads return receive FIFO head.
// - Short characters: transmitter ignores high bits, receiver returns them as zero.
// - Data write while buffer-empty flag is clear is discarded.
// - Enabled transmitter loads buffer into empty shift register, shifts it out.
// - Receive buffer is a two-entry FIFO; each data read pops head.
// - Receive-complete follows FIFO not-empty; receiver disable flushes and clears it.
// - Transmit-complete sets after frame ends with empty buffer; ack or one clears.
// - Buffer-empty reads one when buffer accepts data; resets to one.
// - Frame-error reports zero first stop bit of head character; write as zero.
// - Overrun sets on start bit with FIFO full and character waiting.
// - Parity-error reports head character parity failure when checking was on.
// - Double-speed bit changes divider ratio sixteen to eight in asynchronous mode.
// - Multi-processor mode drops frames without address information; transmitter unaffected.
// - Each interrupt request needs its enable, global enable and flag set.
// - Receiver enable takes receive pin; disable flushes FIFO and error flags.
// - Transmitter enable takes pin; disable waits for shifter and buffer empty.
// - Ninth received bit of head shown; software reads it before low byte.
// - Software sets ninth transmit bit first; device latches it with byte.
// - Mode bit zero selects asynchronous, one selects synchronous operation.
// - Parity field 00 off, 01 reserved, 10 even, 11 odd.
// - Stop select gives one or two transmitted stop bits; receiver unaffected.
// - Size codes 000..011 give 5..8 bits, 111 gives 9, others reserved.
// - Twelve-bit baud divider in two parts; low write reloads prescaler.
package usrif_pkg;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_STATUS_A = 8'h04;
	localparam logic [7:0] OFS_CONTROL_B = 8'h08;
	localparam logic [7:0] OFS_FRAME = 8'h0C;
	localparam logic [7:0] OFS_BAUD_LOW = 8'h10;
	localparam logic [7:0] OFS_BAUD_HIGH = 8'h14;
	localparam logic [7:0] RST_STATUS_A = 8'h20;
	localparam logic [7:0] RST_CONTROL_B = 8'h00;
	localparam logic [7:0] RST_FRAME = 8'h00;
	localparam logic [11:0] RST_BAUD = 12'h000;
	localparam int BIT_RXC = 7;
	localparam int BIT_TXC = 6;
	localparam int BIT_U2X = 1;
	localparam int BIT_MPCM = 0;
	localparam int BIT_RXEN = 4;
	localparam int BIT_TXEN = 3;
	localparam int BIT_UCSZ2 = 2;
	localparam int BIT_TXB8 = 0;
	localparam int BIT_MODE = 6;
	localparam int BIT_STOP2 = 3;
	localparam logic [4:0] RATIO_NORMAL = 5'h10;
	localparam logic [4:0] RATIO_DOUBLE = 5'h08;
	localparam logic [4:0] RATIO_SYNC = 5'h02;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [2:0] SIZE_NINE = 3'h7;
	typedef enum logic [5:0] {
		TX_IDLE = 6'b00_0001, TX_START = 6'b00_0010, TX_DATA = 6'b00_0100,
		TX_PAR = 6'b00_1000, TX_STOP1 = 6'b01_0000, TX_STOP2 = 6'b10_0000
	} usrif_tx_e;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b0_0001, RX_START = 5'b0_0010, RX_DATA = 5'b0_0100,
		RX_PAR = 5'b0_1000, RX_STOP = 5'b1_0000
	} usrif_rx_e;
endpackage

// ===== core/usrif_top.sv
// Serial port register block with transmitter, receiver and two-entry receive FIFO.
// Assumes an AHB-Lite master on SYS_CLK_I and an asynchronous peer on RXD_I/TXD_O.
`timescale 1ns/10ps
`default_nettype none
module usrif_top
	import usrif_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// Core interrupt side
	input wire logic GIE_I,
	input wire logic TXC_ACK_I,
	output logic IRQ_RXC_O,
	output logic IRQ_TXC_O,
	output logic IRQ_UDRE_O,
	// Serial pins
	input wire logic RXD_I,
	output logic TXD_O,
	output logic TXD_OE_O,
	output logic RXD_OWN_O
);
	logic rst_m_q, rst_n;
	logic [1:0] rxd_sync_q;
	logic a_sel_q, a_wr_q;
	logic [7:0] a_ofs_q;
	logic [31:0] rdata_q;
	logic rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, ucsz2_q, txb8_q;
	logic u2x_q, mpcm_q, txc_q, dor_q, mode_q, stop2_q;
	logic [1:0] upm_q, ucsz_q;
	logic [11:0] baud_q, pre_q;
	logic irq_rx_q, irq_tx_q, irq_ud_q;
	logic [8:0] tbuf_q, tsh_q;
	logic tbuf_v_q, tx_own_q, txd_q;
	usrif_tx_e tx_st_q;
	logic [4:0] tx_os_q, rx_os_q;
	logic [3:0] tx_bit_q, rx_bit_q;
	usrif_rx_e rx_st_q;
	logic [8:0] rsh_q;
	logic rpar_q;
	logic [10:0] ent0_q, ent1_q, wait_q;
	logic [1:0] cnt_q;
	logic wait_v_q;

	// Reset release through two flops
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_m_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n <= rst_m_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) rxd_sync_q <= 2'b11;
		else rxd_sync_q <= {rxd_sync_q[0], RXD_I};
	end
	wire rxd_s = rxd_sync_q[1];

	// Bus decode; zero wait states, address phase read, data phase write
	wire a_take = HSEL_I & HTRANS_I[1] & HREADY_I;
	wire [7:0] a_ofs = HADDR_I[7:0];
	wire rd_take = a_take & ~HWRITE_I;
	wire wr_now = a_sel_q & a_wr_q;
	wire [7:0] wd = HWDATA_I[7:0];
	wire wr_data = wr_now & (a_ofs_q == OFS_DATA);
	wire wr_sta = wr_now & (a_ofs_q == OFS_STATUS_A);
	wire wr_ctl = wr_now & (a_ofs_q == OFS_CONTROL_B);
	wire wr_frm = wr_now & (a_ofs_q == OFS_FRAME);
	wire wr_bl = wr_now & (a_ofs_q == OFS_BAUD_LOW);
	wire wr_bh = wr_now & (a_ofs_q == OFS_BAUD_HIGH);
	wire rd_data = rd_take & (a_ofs == OFS_DATA);

	// Frame shape
	wire nine = ({ucsz2_q, ucsz_q} == SIZE_NINE);
	wire [3:0] nbits = nine ? 4'd9 : (ucsz2_q ? 4'd8 : {2'b01, ucsz_q} + 4'd1);
	wire [8:0] mask = nine ? 9'h1FF : (9'h0FF >> (4'd8 - nbits));
	wire par_on = upm_q[1];
	wire par_odd = upm_q[0];
	wire [4:0] ratio = mode_q ? RATIO_SYNC : (u2x_q ? RATIO_DOUBLE : RATIO_NORMAL);
	wire [4:0] half = {1'b0, ratio[4:1]};
	wire tick = (pre_q == 12'h000);

	// Receive FIFO status
	wire rx_any = (cnt_q != 2'd0);
	wire pop = rd_data & rx_any;
	wire rxc = rx_any & rxen_q;
	wire udre = ~tbuf_v_q;
	wire [7:0] sta_rd = {rxc, txc_q, udre, ent0_q[9] & rx_any, dor_q,
		ent0_q[10] & rx_any, u2x_q, mpcm_q};
	wire [7:0] ctl_rd = {rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, ucsz2_q,
		ent0_q[8] & rx_any, txb8_q};
	wire [7:0] frm_rd = {1'b0, mode_q, upm_q, stop2_q, ucsz_q, 1'b0};
	wire [7:0] data_rd = rx_any ? ent0_q[7:0] : 8'h00;
	wire [7:0] rd_mux = (a_ofs == OFS_DATA) ? data_rd :
		(a_ofs == OFS_STATUS_A) ? sta_rd :
		(a_ofs == OFS_CONTROL_B) ? ctl_rd :
		(a_ofs == OFS_FRAME) ? frm_rd :
		(a_ofs == OFS_BAUD_LOW) ? baud_q[7:0] :
		(a_ofs == OFS_BAUD_HIGH) ? {4'h0, baud_q[11:8]} : 8'h00;

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			a_sel_q <= 1'b0;
			a_wr_q <= 1'b0;
			a_ofs_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			a_sel_q <= a_take;
			a_wr_q <= HWRITE_I;
			a_ofs_q <= a_ofs;
			rdata_q <= rd_take ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end
	end

	// Control registers
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			{rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, ucsz2_q} <= RST_CONTROL_B[7:2];
			txb8_q <= RST_CONTROL_B[BIT_TXB8];
			u2x_q <= RST_STATUS_A[BIT_U2X];
			mpcm_q <= RST_STATUS_A[BIT_MPCM];
			mode_q <= RST_FRAME[BIT_MODE];
			upm_q <= RST_FRAME[5:4];
			stop2_q <= RST_FRAME[BIT_STOP2];
			ucsz_q <= RST_FRAME[2:1];
		end else begin
			if (wr_ctl) begin
				{rxcie_q, txcie_q, udrie_q, rxen_q, txen_q, ucsz2_q} <= wd[7:2];
				txb8_q <= wd[BIT_TXB8];
			end
			if (wr_sta) begin
				u2x_q <= wd[BIT_U2X];
				mpcm_q <= wd[BIT_MPCM];
			end
			if (wr_frm) begin
				mode_q <= wd[BIT_MODE];
				upm_q <= wd[5:4];
				stop2_q <= wd[BIT_STOP2];
				ucsz_q <= wd[2:1];
			end
		end
	end

	// Baud divider; low write restarts prescaler at once
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			baud_q <= RST_BAUD;
			pre_q <= RST_BAUD;
		end else begin
			if (wr_bh) baud_q[11:8] <= wd[3:0];
			if (wr_bl) begin
				baud_q[7:0] <= wd;
				pre_q <= {baud_q[11:8], wd};
			end else if (tick) begin
				pre_q <= baud_q;
			end else begin
				pre_q <= pre_q - 12'h001;
			end
		end
	end

	// Interrupt requests and transmit-complete flag
	wire tx_last = (tx_os_q == ratio - 5'd1) & tick;
	wire tx_end = tx_last & ((tx_st_q == TX_STOP2) | ((tx_st_q == TX_STOP1) & ~stop2_q));
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			txc_q <= RST_STATUS_A[BIT_TXC];
			irq_rx_q <= 1'b0;
			irq_tx_q <= 1'b0;
			irq_ud_q <= 1'b0;
		end else begin
			if (tx_end & ~tbuf_v_q) txc_q <= 1'b1;
			else if (TXC_ACK_I | (wr_sta & wd[BIT_TXC])) txc_q <= 1'b0;
			irq_rx_q <= rxcie_q & GIE_I & rxc;
			irq_tx_q <= txcie_q & GIE_I & txc_q;
			irq_ud_q <= udrie_q & GIE_I & udre;
		end
	end

	// Transmit buffer and shifter
	wire tx_load = (tx_st_q == TX_IDLE) & tbuf_v_q & tx_own_q;
	wire tx_par = ^(tsh_q & mask) ^ par_odd;
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			tbuf_q <= 9'h000;
			tbuf_v_q <= 1'b0;
		end else if (wr_data & udre) begin
			tbuf_q <= {txb8_q, wd};
			tbuf_v_q <= 1'b1;
		end else if (tx_load) begin
			tbuf_v_q <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q <= TX_IDLE;
			tsh_q <= 9'h000;
			tx_os_q <= 5'd0;
			tx_bit_q <= 4'd0;
		end else begin
			if (tx_st_q == TX_IDLE) tx_os_q <= 5'd0;
			else if (tick) tx_os_q <= tx_last ? 5'd0 : tx_os_q + 5'd1;
			case (tx_st_q)
				TX_IDLE: begin
					if (tx_load) begin
						tsh_q <= tbuf_q & mask;
						tx_bit_q <= 4'd0;
						tx_st_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_last) tx_st_q <= TX_DATA;
				end
				TX_DATA: begin
					if (tx_last) begin
						tx_bit_q <= tx_bit_q + 4'd1;
						if (tx_bit_q == nbits - 4'd1) tx_st_q <= par_on ? TX_PAR : TX_STOP1;
					end
				end
				TX_PAR: begin
					if (tx_last) tx_st_q <= TX_STOP1;
				end
				TX_STOP1: begin
					if (tx_last) tx_st_q <= stop2_q ? TX_STOP2 : TX_IDLE;
				end
				TX_STOP2: begin
					if (tx_last) tx_st_q <= TX_IDLE;
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	// Pin line level and ownership
	wire txd_d = (tx_st_q == TX_START) ? 1'b0 :
		(tx_st_q == TX_DATA) ? tsh_q[tx_bit_q] :
		(tx_st_q == TX_PAR) ? tx_par : 1'b1;
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			txd_q <= 1'b1;
			tx_own_q <= 1'b0;
		end else begin
			txd_q <= txd_d;
			// Disable waits for shifter and buffer to drain
			tx_own_q <= txen_q | (tx_st_q != TX_IDLE) | tbuf_v_q;
		end
	end

	// Receiver
	wire rx_last = (rx_os_q == ratio - 5'd1) & tick;
	wire rx_mid = (rx_os_q == half - 5'd1) & tick;
	wire rx_done = (rx_st_q == RX_STOP) & rx_last;
	wire rx_fe = ~rxd_s;
	wire rx_pe = par_on & (^(rsh_q & mask) ^ par_odd ^ rpar_q);
	// Address mark is ninth bit, or the first stop bit for shorter characters
	wire rx_addr = nine ? rsh_q[8] : rxd_s;
	wire rx_keep = ~mpcm_q | rx_addr;
	wire [10:0] rx_ent = {rx_pe, rx_fe, rsh_q & mask};
	wire rx_push = rx_done & rx_keep;
	wire rx_begin = (rx_st_q == RX_IDLE) & ~rxd_s & rxen_q;

	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= RX_IDLE;
			rsh_q <= 9'h000;
			rpar_q <= 1'b0;
			rx_os_q <= 5'd0;
			rx_bit_q <= 4'd0;
		end else if (!rxen_q) begin
			rx_st_q <= RX_IDLE;
			rx_os_q <= 5'd0;
		end else begin
			if (rx_st_q == RX_IDLE) rx_os_q <= 5'd0;
			else if ((rx_st_q == RX_START) ? rx_mid : rx_last) rx_os_q <= 5'd0;
			else if (tick) rx_os_q <= rx_os_q + 5'd1;
			case (rx_st_q)
				RX_IDLE: begin
					if (rx_begin) begin
						rsh_q <= 9'h000;
						rx_bit_q <= 4'd0;
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					// Glitch on start bit returns to idle
					if (rx_mid) rx_st_q <= rxd_s ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rx_last) begin
						rsh_q[rx_bit_q] <= rxd_s;
						rx_bit_q <= rx_bit_q + 4'd1;
						if (rx_bit_q == nbits - 4'd1) rx_st_q <= par_on ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					if (rx_last) begin
						rpar_q <= rxd_s;
						rx_st_q <= RX_STOP;
					end
				end
				// Only the first stop bit is checked, whatever the stop setting
				RX_STOP: begin
					if (rx_last) rx_st_q <= RX_IDLE;
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Two-entry FIFO plus one waiting character in a separate wait register
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ent0_q <= 11'h000;
			ent1_q <= 11'h000;
			wait_q <= 11'h000;
			cnt_q <= 2'd0;
			wait_v_q <= 1'b0;
		end else if (!rxen_q) begin
			cnt_q <= 2'd0;
			wait_v_q <= 1'b0;
		end else begin
			case ({pop, rx_push})
				2'b10: begin
					ent0_q <= ent1_q;
					if (cnt_q == 2'd2 && wait_v_q) begin
						ent1_q <= wait_q;
						wait_v_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 2'd1;
					end
				end
				2'b01: begin
					if (cnt_q == 2'd0) ent0_q <= rx_ent;
					if (cnt_q == 2'd1) ent1_q <= rx_ent;
					if (cnt_q != 2'd2) cnt_q <= cnt_q + 2'd1;
					else if (!wait_v_q) begin
						wait_q <= rx_ent;
						wait_v_q <= 1'b1;
					end
				end
				2'b11: begin
					if (cnt_q == 2'd1) ent0_q <= rx_ent;
					else begin
						ent0_q <= ent1_q;
						ent1_q <= wait_v_q ? wait_q : rx_ent;
						if (wait_v_q) wait_q <= rx_ent;
					end
				end
				default: begin
					cnt_q <= cnt_q;
				end
			endcase
		end
	end

	// Overrun flag; a new overrun wins over the clearing read
	always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
		if (!rst_n) dor_q <= 1'b0;
		else if (!rxen_q) dor_q <= 1'b0;
		else if (rx_begin & (cnt_q == 2'd2) & wait_v_q) dor_q <= 1'b1;
		else if (rd_data) dor_q <= 1'b0;
	end

	assign HRDATA_O = rdata_q;
	assign HREADYOUT_O = rst_n;
	assign HRESP_O = 1'b0 & rst_n;
	assign IRQ_RXC_O = irq_rx_q;
	assign IRQ_TXC_O = irq_tx_q;
	assign IRQ_UDRE_O = irq_ud_q;
	assign TXD_O = txd_q;
	assign TXD_OE_O = tx_own_q;
	assign RXD_OWN_O = rxen_q;
endmodule
`default_nettype wire

// ===== testbench/usrif_chk.sv
// Port assertions for the serial register block.
// Assumes binding into usrif_top; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module usrif_chk
	import usrif_pkg::*;
(
	// Clock and reset
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// Bus
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HRDATA_O,
	// Events and pins
	input wire logic GIE_I,
	input wire logic TXC_ACK_I,
	input wire logic IRQ_RXC_O,
	input wire logic IRQ_TXC_O,
	input wire logic IRQ_UDRE_O,
	input wire logic TXD_O,
	input wire logic TXD_OE_O,
	input wire logic RXD_OWN_O
);
	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!NRST_I);
	wire logic take = HSEL_I && HTRANS_I[1] && HREADY_I;
	wire logic ctl_take = take && HWRITE_I && HADDR_I[7:0] == OFS_CONTROL_B;
	sequence s_ctl_write;
		ctl_take ##1 1'h1;
	endsequence
	sequence s_start_bit;
		$fell(TXD_O);
	endsequence
	// Ack away from any frame end, so a set cannot win
	sequence s_ack_idle;
		TXC_ACK_I && !TXD_OE_O && $past(!TXD_OE_O);
	endsequence
	AST_RDATA_PHASE: assert property (
		|HRDATA_O |-> $past(take && !HWRITE_I) && !(|HRDATA_O[31:8]))
		else $error("read data outside read phase");
	AST_RXEN_WRITE: assert property (
		s_ctl_write |=> RXD_OWN_O == $past(HWDATA_I[BIT_RXEN]))
		else $error("rx owner not from write");
	AST_RXEN_ONLY: assert property (
		$changed(RXD_OWN_O) |-> $past(ctl_take, 2))
		else $error("rx owner changed alone");
	AST_IRQ_RXC_GIE: assert property (
		!GIE_I |=> !IRQ_RXC_O)
		else $error("rx irq while masked");
	AST_IRQ_TXC_GIE: assert property (
		IRQ_TXC_O |-> $past(GIE_I))
		else $error("tx irq while masked");
	AST_IRQ_UDRE_GIE: assert property (
		$rose(IRQ_UDRE_O) |-> $past(GIE_I))
		else $error("empty irq while masked");
	AST_TXC_ACK: assert property (
		s_ack_idle |=> ##1 !IRQ_TXC_O)
		else $error("tx irq survived ack");
	AST_START_BIT: assert property (
		s_start_bit |-> (TXD_OE_O && !TXD_O) [*2])
		else $error("short start bit");
	AST_OE_IDLE: assert property (
		$fell(TXD_OE_O) |-> $past(TXD_O))
		else $error("tx pin freed mid frame");
endmodule
bind usrif_top usrif_chk usrif_chk_inst (
	.SYS_CLK_I, .NRST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HWDATA_I,
	.HREADY_I, .HRDATA_O, .GIE_I, .TXC_ACK_I, .IRQ_RXC_O, .IRQ_TXC_O,
	.IRQ_UDRE_O, .TXD_O, .TXD_OE_O, .RXD_OWN_O
);
`default_nettype wire

// ===== testbench/usrif_peer.sv
// Remote serial peer: sends frames on RxD, captures frames on TxD.
// Assumes the block's clock and a fixed bit time of BT clocks.
`timescale 1ns/10ps
`default_nettype none
module usrif_peer #(
	parameter int BT = 8
) (
	// Clock
	input wire logic clk_i,
	// Serial lines
	input wire logic txd_i,
	output logic rxd_o
);
	logic [8:0] got;
	logic [8:0] got_q[$];
	int nbits = 8;
	initial rxd_o = 1'h1;
	// LSB first; parity is passed in as an extra top bit
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		rxd_o <= 1'h0;
		repeat (BT) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rxd_o <= d[i];
			repeat (BT) @(posedge clk_i);
		end
		rxd_o <= stop;
		repeat (BT) @(posedge clk_i);
		rxd_o <= 1'h1;
		repeat (BT) @(posedge clk_i);
	endtask
	// Mid-bit sampling of each transmitted frame
	always begin
		@(negedge txd_i);
		got = '0;
		repeat (BT / 2) @(posedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			repeat (BT) @(posedge clk_i);
			got[i] = txd_i;
		end
		repeat (BT) @(posedge clk_i);
		got_q.push_back(got);
	end
endmodule
`default_nettype wire

// ===== testbench/uart_register_interface_tb.sv
// Self-checking bench for the serial register block.
// Assumes 10 MHz clock; double speed, divider 0 gives 8 clocks a bit.
`timescale 1ns/10ps
`default_nettype none
module uart_register_interface_tb;
	import usrif_pkg::*;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic gie = 1'h0;
	logic txc_ack = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hrdy, hresp, irq_rxc, irq_txc, irq_udre, rxd, txd, txd_oe, rxd_own;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	usrif_top usrif_top_inst (
		.SYS_CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.GIE_I(gie), .TXC_ACK_I(txc_ack), .IRQ_RXC_O(irq_rxc), .IRQ_TXC_O(irq_txc),
		.IRQ_UDRE_O(irq_udre), .RXD_I(rxd), .TXD_O(txd), .TXD_OE_O(txd_oe),
		.RXD_OWN_O(rxd_own)
	);
	// TxD line pulled up while the transmitter has released the pin
	usrif_peer #(.BT(8)) usrif_peer_inst (.clk_i(clk), .txd_i(txd_oe ? txd : 1'h1), .rxd_o(rxd));
	initial forever #50 clk = ~clk;
	task automatic summarize();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hrdy !== 1'h1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] rd;
		bus(1'h1, a, wd, rd);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'h0, a, '0, rd);
		chk(nm, exp, rd);
	endtask
	task automatic t_reset();
		rdc("status", OFS_STATUS_A, 32'h0000_0020);
		rdc("control", OFS_CONTROL_B, 32'h0000_0000);
		rdc("unmapped", 8'h18, 32'h0000_0000);
		chk("resp", 32'h0000_0000, hresp);
		wr(OFS_FRAME, 32'h0000_0006);
		wr(OFS_STATUS_A, 32'h0000_0002);
		wr(OFS_BAUD_LOW, 32'h0000_0000);
		rdc("frame", OFS_FRAME, 32'h0000_0006);
	endtask
	task automatic t_tx();
		gie <= 1'h1;
		wr(OFS_CONTROL_B, 32'h0000_0058);
		wr(OFS_DATA, 32'h0000_00A5);
		wr(OFS_DATA, 32'h0000_0011);
		wr(OFS_DATA, 32'h0000_0022);
		rdc("busy", OFS_STATUS_A, 32'h0000_0002);
		repeat (400) if (irq_txc !== 1'h1) @(posedge clk);
		chk("tx irq", 32'h0000_0001, irq_txc);
		chk("tx count", 32'h0000_0002, usrif_peer_inst.got_q.size());
		chk("tx first", 32'h0000_00A5, usrif_peer_inst.got_q[0]);
		chk("tx second", 32'h0000_0011, usrif_peer_inst.got_q[1]);
		rdc("tx done", OFS_STATUS_A, 32'h0000_0062);
		wr(OFS_CONTROL_B, 32'h0000_0050);
		rdc("tx off", OFS_STATUS_A, 32'h0000_0062);
		chk("tx pin", 32'h0000_0000, txd_oe);
		txc_ack <= 1'h1;
		@(posedge clk);
		txc_ack <= 1'h0;
		repeat (2) @(posedge clk);
		chk("tx irq ack", 32'h0000_0000, irq_txc);
		rdc("ack status", OFS_STATUS_A, 32'h0000_0022);
		wr(OFS_CONTROL_B, 32'h0000_0030);
		repeat (2) @(posedge clk);
		chk("empty irq", 32'h0000_0001, irq_udre);
		gie <= 1'h0;
		repeat (2) @(posedge clk);
		chk("empty masked", 32'h0000_0000, irq_udre);
	endtask
	task automatic t_rx();
		usrif_peer_inst.send(9'h05A, 8, 1'h1);
		usrif_peer_inst.send(9'h0C3, 8, 1'h0);
		rdc("rx status", OFS_STATUS_A, 32'h0000_00A2);
		rdc("rx first", OFS_DATA, 32'h0000_005A);
		rdc("rx fe", OFS_STATUS_A, 32'h0000_00B2);
		rdc("rx second", OFS_DATA, 32'h0000_00C3);
		rdc("rx empty", OFS_STATUS_A, 32'h0000_0022);
	endtask
	task automatic t_parity();
		wr(OFS_FRAME, 32'h0000_0026);
		usrif_peer_inst.send(9'h05A, 9, 1'h1);
		usrif_peer_inst.send(9'h15A, 9, 1'h1);
		rdc("even ok", OFS_STATUS_A, 32'h0000_00A2);
		rdc("even data", OFS_DATA, 32'h0000_005A);
		rdc("even bad", OFS_STATUS_A, 32'h0000_00A6);
		rdc("bad data", OFS_DATA, 32'h0000_005A);
		wr(OFS_FRAME, 32'h0000_0036);
		usrif_peer_inst.send(9'h15A, 9, 1'h1);
		rdc("odd ok", OFS_STATUS_A, 32'h0000_00A2);
		rdc("odd data", OFS_DATA, 32'h0000_005A);
		wr(OFS_FRAME, 32'h0000_0000);
		usrif_peer_inst.send(9'h1FF, 5, 1'h1);
		rdc("short rx", OFS_DATA, 32'h0000_001F);
	endtask
	task automatic t_overrun();
		wr(OFS_FRAME, 32'h0000_0006);
		for (int i = 0; i < 4; i++) begin
			usrif_peer_inst.send(9'h030 + 9'(i), 8, 1'h1);
		end
		rdc("overrun", OFS_STATUS_A, 32'h0000_00AA);
		rdc("ovr head", OFS_DATA, 32'h0000_0030);
		rdc("ovr read", OFS_STATUS_A, 32'h0000_00A2);
		chk("rx owner", 32'h0000_0001, rxd_own);
		wr(OFS_CONTROL_B, 32'h0000_0000);
		rdc("flushed", OFS_STATUS_A, 32'h0000_0022);
		chk("rx freed", 32'h0000_0000, rxd_own);
	endtask
	// Edges from the data write until the transmit-complete request shows
	task automatic wait_txc(output int n);
		n = 0;
		while (irq_txc !== 1'h1 && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Nine-bit frames; frame lengths compared, so fixed latencies cancel
	task automatic t_nine();
		int n1;
		int n2;
		int n3;
		usrif_peer_inst.nbits = 9;
		gie <= 1'h1;
		wr(OFS_FRAME, 32'h0000_0006);
		wr(OFS_CONTROL_B, 32'h0000_005D);
		wr(OFS_DATA, 32'h0000_003C);
		wait_txc(n1);
		wr(OFS_STATUS_A, 32'h0000_0042);
		rdc("txc cleared", OFS_STATUS_A, 32'h0000_0022);
		wr(OFS_FRAME, 32'h0000_000E);
		wr(OFS_CONTROL_B, 32'h0000_005C);
		wr(OFS_DATA, 32'h0000_00C3);
		wait_txc(n2);
		chk("nine tx", 32'h0000_013C, usrif_peer_inst.got_q[2]);
		chk("nine tx low", 32'h0000_00C3, usrif_peer_inst.got_q[3]);
		chk("second stop", 32'h0000_0008, n2 - n1);
		usrif_peer_inst.send(9'h1A5, 9, 1'h1);
		rdc("rx ninth", OFS_CONTROL_B, 32'h0000_005E);
		rdc("rx nine low", OFS_DATA, 32'h0000_00A5);
		wr(OFS_STATUS_A, 32'h0000_0003);
		usrif_peer_inst.send(9'h0A5, 9, 1'h1);
		usrif_peer_inst.send(9'h1C3, 9, 1'h1);
		rdc("filtered", OFS_DATA, 32'h0000_00C3);
		// Peer captures at normal speed are not checked; its bit time is fixed
		wr(OFS_STATUS_A, 32'h0000_0040);
		wr(OFS_DATA, 32'h0000_00C3);
		wait_txc(n3);
		chk("normal speed", 32'h0000_0060, n3 - n2);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		repeat (3) @(posedge clk);
		t_reset();
		t_tx();
		t_rx();
		t_parity();
		t_overrun();
		t_nine();
		summarize();
	end
endmodule
`default_nettype wire
